// ===== dv/opt_channel_properties.sv
`timescale 1ns/1ps
module opt_channel_properties
  import opt_pkg::*;
(
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire opt_pkg::opt_wb_req_type wb_req_i,
  input wire opt_pkg::opt_wb_rsp_type wb_rsp_o,
  input wire logic                    channel_pulse_pin_o,
  input wire logic                    irq_o
);
  logic req;
  logic used_q;
  assign req = wb_req_i.cyc && wb_req_i.stb;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      used_q <= 1'b0;
    end else if (req && wb_req_i.we) begin
      used_q <= 1'b1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_after_req: assert property (req && !wb_rsp_o.ack |=> wb_rsp_o.ack)
    else $error("ack late");
  a_ack_one_cycle: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("ack held");
  a_ack_needs_req: assert property (!req |=> !wb_rsp_o.ack)
    else $error("stray ack");
  a_upper_half_zero: assert property (wb_rsp_o.ack |-> wb_rsp_o.dat[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_unmapped_zero: assert property (wb_rsp_o.ack && !wb_req_i.we && wb_req_i.adr == 4'hc |-> wb_rsp_o.dat == 32'h0)
    else $error("unmapped read not zero");
  a_reset_quiet: assert property ($fell(rst_i) |-> !channel_pulse_pin_o && !irq_o && !wb_rsp_o.ack)
    else $error("outputs active after reset");
  a_pulse_needs_run: assert property (!used_q |-> !channel_pulse_pin_o)
    else $error("pulse before any write");
  a_irq_needs_run: assert property (!used_q |-> !irq_o)
    else $error("irq before any write");
endmodule

bind opt_channel opt_channel_properties u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
  .channel_pulse_pin_o(channel_pulse_pin_o), .irq_o(irq_o));

// ===== dv/opt_ext_model.sv
`timescale 1ns/1ps
// trigger pin, wrap events and free sub-clock
module opt_ext_model
  import opt_pkg::*;
(
  input  wire logic            clk_i,
  input  wire logic            fire_i,
  input  wire logic [1:0]      src_i,
  input  wire logic            idx_i,
  output opt_pkg::opt_ext_type ext_o
);
  logic [4:0] div_q = 5'h00;
  initial ext_o = '0;
  always @(posedge clk_i) begin
    div_q <= div_q + 5'h01;
    ext_o.subclk_div32 <= div_q[4];
    ext_o.trig_pin <= fire_i && src_i == 2'h0;
    ext_o.group2_wrap <= fire_i && src_i == 2'h1;
    ext_o.prev_wrap <= fire_i && src_i == 2'h2;
    ext_o.next_wrap <= fire_i && src_i == 2'h3;
    ext_o.index_pin <= idx_i; // held for several steps by the bench
  end
endmodule

// ===== dv/test_oneshot_pwm_timer_channel.sv
`timescale 1ns/1ps
module test_oneshot_pwm_timer_channel;
  import opt_pkg::*;
  logic           clk_i = 1'b0;
  logic           rst_i = 1'b1;
  logic           fire = 1'b0;
  logic [1:0]     src = 2'h0;
  logic           qstep = 1'b0;
  logic           qup = 1'b0;
  logic           idx = 1'b0;
  opt_wb_req_type req = '0;
  opt_wb_rsp_type rsp;
  opt_ext_type    ext;
  logic           pin;
  logic           irq;
  logic [31:0]    rd;
  int             n_mismatch = 0;
  int             n_checks = 0;
  int             hi, per, ni;
  int             dv [4] = '{1, 2, 8, 32};

  opt_channel uut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp), .ext_i(ext),
    .quad_step_i(qstep), .quad_up_i(qup), .channel_pulse_pin_o(pin), .irq_o(irq), .wrap_o());
  opt_ext_model u_ext (.clk_i(clk_i), .fire_i(fire), .src_i(src), .idx_i(idx), .ext_o(ext));

  initial forever #20 clk_i = ~clk_i;

  task summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task check(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int t;
    t = 0;
    req <= '{1'b1, 1'b1, w, a, 4'hf, d};
    @(posedge clk_i);
    while (rsp.ack !== 1'b1 && t < 50) begin
      @(posedge clk_i);
      t++;
    end
    if (t == 50) n_mismatch++;
    rd = rsp.dat;
    req <= '0;
    @(posedge clk_i);
  endtask

  task fire1;
    fire <= 1'b1;
    @(posedge clk_i);
    fire <= 1'b0;
  endtask

  // high time, rise-to-rise time and irq count
  task meas(input int lim);
    int t;
    hi = 0; per = 0; ni = 0; t = 0;
    while (pin !== 1'b1 && t < lim) begin @(posedge clk_i); t++; end
    while (pin === 1'b1 && hi < lim) begin @(posedge clk_i); hi++; ni += int'(irq === 1'b1); end
    per = hi;
    while (pin !== 1'b1 && per < lim) begin @(posedge clk_i); per++; ni += int'(irq === 1'b1); end
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int a = 0; a < 16; a += 4) if (a != 8) begin
      wb(1'b0, 4'(a), 32'h0);
      check(rd, 32'h0);
    end
    // one-shot: clock selects f1 to f32, each paired with the trigger source of the same number
    for (int c = 0; c < 4; c++) begin
      src <= 2'(c);
      wb(1'b1, OFF_COUNT, 32'h3);
      wb(1'b1, OFF_CTRL, 32'h21 | 32'(c << 6) | 32'(c << 9));
      fork meas(300); fire1(); join
      check(32'(hi > 2 * dv[c] && hi <= 4 * dv[c]), 32'h1);
      check(32'(ni), 32'h1);
      check({31'h0, pin}, 32'h0);
      wb(1'b1, OFF_CTRL, 32'h0);
    end
    // retrigger while counting
    src <= 2'h0;
    wb(1'b1, OFF_COUNT, 32'h6);
    wb(1'b1, OFF_CTRL, 32'h21);
    fork meas(300); begin fire1(); repeat (3) @(posedge clk_i); fire1(); end join
    check(32'(hi >= 9 && hi <= 11), 32'h1);
    wb(1'b1, OFF_CTRL, 32'h0);
    // zero count stays inactive, soft trigger starts, run clear stops
    wb(1'b1, OFF_COUNT, 32'h0);
    wb(1'b1, OFF_CTRL, 32'h23);
    repeat (10) @(posedge clk_i);
    check({31'h0, pin}, 32'h0);
    wb(1'b1, OFF_CTRL, 32'h0);
    wb(1'b1, OFF_COUNT, 32'h100);
    wb(1'b1, OFF_CTRL, 32'h23);
    check({31'h0, pin}, 32'h1);
    wb(1'b1, OFF_CTRL, 32'h0);
    check({31'h0, pin}, 32'h0);
    // 8-bit pwm, n=2 m=1, started by run bit alone
    wb(1'b1, OFF_COUNT, 32'h0201);
    wb(1'b1, OFF_CTRL, 32'h2d);
    meas(2000);
    fork meas(2000); fire1(); join
    check(32'(hi), 32'd4);
    check(32'(per), 32'd510);
    check(32'(ni), 32'h1);
    wb(1'b1, OFF_CTRL, 32'h0);
    // 16-bit pwm in trigger mode
    wb(1'b1, OFF_COUNT, 32'h5);
    wb(1'b1, OFF_CTRL, 32'h35);
    repeat (5) @(posedge clk_i);
    check({31'h0, pin}, 32'h0);
    fork meas(70000); fire1(); join
    check(32'(hi), 32'd5);
    check(32'(per), 32'd65535);
    wb(1'b1, OFF_CTRL, 32'h0);
    repeat (3) @(posedge clk_i);
    check({31'h0, pin}, 32'h0);
    // index clear on third channel, quad x4, rising edge
    wb(1'b1, OFF_COUNT, 32'h0);
    wb(1'b1, OFF_CTRL, 32'h7800);
    qup <= 1'b1;
    qstep <= 1'b1;
    repeat (3) @(posedge clk_i);
    qstep <= 1'b0;
    wb(1'b0, OFF_COUNT, 32'h0);
    check(rd, 32'h3);
    idx <= 1'b1;
    repeat (4) @(posedge clk_i);
    wb(1'b0, OFF_COUNT, 32'h0);
    check(rd, 32'h3);
    qstep <= 1'b1;
    @(posedge clk_i);
    qstep <= 1'b0;
    idx <= 1'b0;
    wb(1'b0, OFF_COUNT, 32'h0);
    check(rd, 32'h0);
    wb(1'b1, OFF_CTRL, 32'h0);
    summarize;
  end

  initial begin
    repeat (90000) @(posedge clk_i);
    n_mismatch++;
    summarize;
  end
endmodule

// ===== hw/opt_channel.sv
`timescale 1ns/1ps
// Operation
// - index clear works only as third channel, quad x4 free-running, index pin
// - index edge detected, rising or falling chosen by polarity bit
// - index edge clears counter at next count clock, not at once
// - overflow coinciding with index clear raises interrupt twice in succession
// - count clock from f1, f2, f8, f32 or subclock divided by 32
// - one-shot counts down, reloads at zero, then stops
// - one-shot trigger while counting reloads and restarts
// - one-shot period n count clocks; zero keeps counter inactive
// - one-shot starts on run bit plus pin, timer wrap or soft trigger
// - one-shot ends on reload after zero or run bit cleared
// - one-shot interrupt when counter reaches zero
// - counter read in one-shot and pwm modes is undefined
// - write while stopped or before first count clock loads counter too
// - pulse output low when idle, high while one-shot counts
// - pwm counts down, reloads at rising edge, ignores triggers
// - 16-bit pwm high n clocks in 65535 clock period
// - 8-bit pwm high n*(m+1) in 255*(m+1) clocks
// - pwm starts on run bit alone or with trigger; run clear stops
// - pwm interrupt at each falling edge of output
module opt_channel
  import opt_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire opt_pkg::opt_wb_req_type wb_req_i,
  output opt_pkg::opt_wb_rsp_type      wb_rsp_o,
  input  wire opt_pkg::opt_ext_type    ext_i,
  input  wire logic                    quad_step_i,
  input  wire logic                    quad_up_i,
  output logic                         channel_pulse_pin_o,
  output logic                         irq_o,
  output logic                         wrap_o
);
  import opt_pkg::*;

  logic [15:0]      ctrl_q;
  logic [CNT_W-1:0] reload_q;
  logic [CNT_W-1:0] cnt_q;
  logic [7:0]       pre_q;
  logic [4:0]       div_q;
  logic             idx_prev_q;
  logic             idx_pend_q;
  logic             pwm_q;
  logic             first_q;
  logic             irq_q;
  logic             irq_again_q;
  logic             wrap_q;
  logic             ack_q;
  logic [31:0]      rdat_q;
  logic             sub_prev_q;
  logic             soft_q;
  opt_state_type    state_q;

  function automatic logic div_tick(input logic [2:0] sel, input logic [4:0] d,
                                    input logic sub_edge);
    unique case (sel)
      CLK_F1:   div_tick = 1'b1;
      CLK_F2:   div_tick = (d[0] == DIV2_LAST[0]);
      CLK_F8:   div_tick = (d[2:0] == DIV8_LAST[2:0]);
      CLK_F32:  div_tick = (d == DIV32_LAST);
      CLK_SUBCLOCK_DIV32: div_tick = sub_edge;
      default:  div_tick = 1'b0;
    endcase
  endfunction

  // bus decode
  wire        bus_go     = wb_req_i.cyc & wb_req_i.stb & ~ack_q;
  wire        bus_wr     = bus_go & wb_req_i.we;
  wire        wr_ctrl    = bus_wr & (wb_req_i.adr == OFF_CTRL);
  wire        wr_cnt     = bus_wr & (wb_req_i.adr == OFF_COUNT);
  wire [15:0] wdat       = wb_req_i.dat[15:0];
  wire [1:0]  lanes      = wb_req_i.sel[1:0];
  wire [15:0] ctrl_wr    = {lanes[1] ? wdat[15:8] : ctrl_q[15:8], lanes[0] ? wdat[7:0] : ctrl_q[7:0]};
  wire [CNT_W-1:0] cnt_wr = {lanes[1] ? wdat[15:8] : reload_q[15:8], lanes[0] ? wdat[7:0] : reload_q[7:0]};

  // control fields
  wire        run        = ctrl_q[CTRL_RUN];
  wire        mode_pwm   = ctrl_q[CTRL_MODE];
  wire        pwm8       = ctrl_q[CTRL_PWM8];
  wire        trg_mode   = ctrl_q[CTRL_TRGMODE];
  wire        pulse_en   = ctrl_q[CTRL_PULSE_EN];
  wire [2:0]  clk_sel    = ctrl_q[CTRL_CLKSEL +: 3];
  wire [1:0]  trg_src    = ctrl_q[CTRL_TRGSRC +: 2];
  wire        soft_trg   = wr_ctrl & ctrl_wr[CTRL_RUN] & ctrl_wr[CTRL_SOFT];
  wire        idx_mode   = ctrl_q[CTRL_IDX_EN] & ctrl_q[CTRL_THIRD] & ctrl_q[CTRL_QUAD];

  // count clock and triggers
  wire sub_edge   = ext_i.subclk_div32 & ~sub_prev_q;
  wire tick       = run & div_tick(clk_sel, div_q, sub_edge);
  wire ext_trg    = (trg_src == 2'b00) ? ext_i.trig_pin :
                    (trg_src == 2'b01) ? ext_i.group2_wrap :
                    (trg_src == 2'b10) ? ext_i.prev_wrap : ext_i.next_wrap;
  wire trigger    = run & (ext_trg | soft_q);
  wire idx_edge   = ext_i.index_pin ^ idx_prev_q;
  wire idx_hit    = idx_mode & idx_edge & (ext_i.index_pin ~^ ctrl_q[CTRL_POL]);
  wire cnt_zero   = (cnt_q == '0);
  wire pre_zero   = (pre_q == 8'h00);
  wire quad_wrap  = quad_step_i & (quad_up_i ? (&cnt_q) : cnt_zero);

  // pwm timing
  wire [15:0] hi16   = reload_q;
  wire [15:0] lo16   = PWM16_PERIOD - reload_q;
  wire [7:0]  hi8    = reload_q[15:8];
  wire [7:0]  lo8    = PWM8_PERIOD - reload_q[15:8];
  wire [15:0] phase_len = pwm8 ? {8'h00, pwm_q ? lo8 : hi8} : (pwm_q ? lo16 : hi16);
  wire        pwm_zero  = pwm8 ? (cnt_q[15:8] == 8'h00) : cnt_zero;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q     <= CTRL_RESET;
      reload_q   <= RELOAD_RESET;
      ack_q      <= 1'b0;
      soft_q     <= 1'b0;
      rdat_q     <= 32'h0000_0000;
    end else begin
      ack_q <= bus_go;
      soft_q <= soft_trg;
      if (wr_ctrl) begin
        ctrl_q <= ctrl_wr & ~(16'h0001 << CTRL_SOFT);
      end
      if (wr_cnt) begin
        reload_q <= cnt_wr;
      end
      if (bus_go && !wb_req_i.we) begin
        unique case (wb_req_i.adr)
          OFF_CTRL:   rdat_q <= {16'h0000, ctrl_q};
          OFF_COUNT:  rdat_q <= {16'h0000, idx_mode ? cnt_q : reload_q};
          OFF_STATUS: rdat_q <= {28'h0000000, first_q, pwm_q, state_q};
          default:    rdat_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q      <= 5'h00;
      sub_prev_q <= 1'b0;
      idx_prev_q <= 1'b0;
    end else begin
      div_q      <= run ? div_q + 5'h01 : 5'h00;
      sub_prev_q <= ext_i.subclk_div32;
      idx_prev_q <= ext_i.index_pin;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q     <= ST_IDLE;
      cnt_q       <= '0;
      pre_q       <= 8'h00;
      pwm_q       <= 1'b0;
      first_q     <= 1'b1;
      idx_pend_q  <= 1'b0;
      irq_q       <= 1'b0;
      irq_again_q <= 1'b0;
      wrap_q      <= 1'b0;
      channel_pulse_pin_o <= 1'b0;
    end else begin
      irq_q       <= irq_again_q;
      irq_again_q <= 1'b0;
      wrap_q      <= 1'b0;
      if (wr_cnt && (state_q != ST_COUNT || first_q)) begin
        cnt_q <= cnt_wr;
      end
      if (idx_mode) begin
        // quadrature counting with index clear
        if (idx_hit) begin
          idx_pend_q <= 1'b1;
        end
        if (quad_step_i) begin
          if (idx_pend_q || idx_hit) begin
            cnt_q      <= '0;
            idx_pend_q <= 1'b0;
            irq_q      <= 1'b1;
            irq_again_q <= quad_wrap;
          end else begin
            cnt_q  <= quad_up_i ? cnt_q + 1'b1 : cnt_q - 1'b1;
            irq_q  <= quad_wrap;
            wrap_q <= quad_wrap;
          end
        end
      end else if (!run) begin
        state_q <= ST_IDLE;
        pwm_q   <= 1'b0;
        first_q <= 1'b1;
        channel_pulse_pin_o <= 1'b0;
      end else if (!mode_pwm) begin
        unique case (state_q)
          ST_IDLE, ST_ARMED: begin
            state_q <= ST_ARMED;
            if (trigger && reload_q != '0) begin
              state_q <= ST_COUNT;
              cnt_q   <= reload_q;
              first_q <= 1'b1;
              channel_pulse_pin_o <= pulse_en;
            end
          end
          ST_COUNT: begin
            if (trigger) begin
              cnt_q <= reload_q;
            end else if (tick) begin
              first_q <= 1'b0;
              if (cnt_q <= CNT_W'(1)) begin
                cnt_q   <= reload_q;
                irq_q   <= 1'b1;
                wrap_q  <= 1'b1;
                state_q <= ST_ARMED;
                channel_pulse_pin_o <= 1'b0;
              end else begin
                cnt_q <= cnt_q - 1'b1;
              end
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end else begin
        unique case (state_q)
          ST_IDLE, ST_ARMED: begin
            state_q <= ST_ARMED;
            if (!trg_mode || trigger) begin
              state_q <= ST_COUNT;
              pwm_q   <= 1'b1;
              cnt_q   <= reload_q;
              pre_q   <= reload_q[7:0];
              first_q <= 1'b1;
              channel_pulse_pin_o <= (phase_len != 16'h0000) || pwm8;
            end
          end
          ST_COUNT: begin
            // triggers ignored while counting
            if (tick) begin
              first_q <= 1'b0;
              if (pwm8 && !pre_zero) begin
                pre_q <= pre_q - 8'h01;
              end else begin
                pre_q <= reload_q[7:0];
                if (pwm8 ? (cnt_q[15:8] <= 8'h01) : (cnt_q <= CNT_W'(1))) begin
                  pwm_q <= ~pwm_q;
                  if (pwm_q) begin
                    irq_q  <= 1'b1;
                    cnt_q  <= pwm8 ? {lo8, reload_q[7:0]} : lo16;
                    channel_pulse_pin_o <= 1'b0;
                  end else begin
                    wrap_q <= 1'b1;
                    cnt_q  <= reload_q;
                    channel_pulse_pin_o <= 1'b1;
                  end
                end else if (pwm8) begin
                  cnt_q[15:8] <= cnt_q[15:8] - 8'h01;
                end else if (!pwm_zero) begin
                  cnt_q <= cnt_q - 1'b1;
                end
              end
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  assign irq_o        = irq_q;
  assign wrap_o       = wrap_q;
  assign wb_rsp_o.ack = ack_q;
  assign wb_rsp_o.dat = rdat_q;
endmodule

// ===== include/opt_pkg.sv
package opt_pkg;
  // register byte offsets
  localparam logic [3:0] OFF_CTRL   = 4'h0;
  localparam logic [3:0] OFF_COUNT  = 4'h4;
  localparam logic [3:0] OFF_STATUS = 4'h8;
  // control field positions
  localparam int CTRL_RUN      = 0;
  localparam int CTRL_SOFT     = 1;
  localparam int CTRL_MODE     = 2;
  localparam int CTRL_PWM8     = 3;
  localparam int CTRL_TRGMODE  = 4;
  localparam int CTRL_PULSE_EN = 5;
  localparam int CTRL_CLKSEL   = 6;
  localparam int CTRL_TRGSRC   = 9;
  localparam int CTRL_IDX_EN   = 11;
  localparam int CTRL_POL      = 12;
  localparam int CTRL_THIRD    = 13;
  localparam int CTRL_QUAD     = 14;
  // reset values
  localparam logic [15:0] CTRL_RESET   = 16'h0000;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  // prescaler last counts and pwm periods
  localparam logic [4:0] DIV2_LAST  = 5'h01;
  localparam logic [4:0] DIV8_LAST  = 5'h07;
  localparam logic [4:0] DIV32_LAST = 5'h1f;
  localparam logic [15:0] PWM16_PERIOD = 16'hffff;
  localparam logic [7:0]  PWM8_PERIOD  = 8'hff;

  typedef enum logic [2:0] {
    CLK_F1    = 3'b000,
    CLK_F2    = 3'b001,
    CLK_F8    = 3'b010,
    CLK_F32   = 3'b011,
    CLK_SUBCLOCK_DIV32  = 3'b100
  } opt_clk_type;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARMED = 2'b01,
    ST_COUNT = 2'b10
  } opt_state_type;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } opt_wb_req_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } opt_wb_rsp_type;

  typedef struct packed {
    logic trig_pin;
    logic group2_wrap;
    logic prev_wrap;
    logic next_wrap;
    logic subclk_div32;
    logic index_pin;
  } opt_ext_type;
endpackage
